// File: common/ssc_pkg.sv
`default_nettype none
package ssc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_WDOG_CTRL  = 8'h00; // Watchdog control
  localparam logic [7:0] ADDR_CTRL0      = 8'h01; // Step mode and current
  localparam logic [7:0] ADDR_LIVE_FAULT = 8'h04; // live_fault_status
  localparam logic [7:0] ADDR_X_OVERLOAD = 8'h05; // x_bridge_overload_status
  localparam logic [7:0] ADDR_Y_OVERLOAD = 8'h06; // y_bridge_overload_status
  localparam logic [7:0] ADDR_STEP_POS   = 8'h07; // step_position_status

  // Field positions
  localparam int CHECK_BIT_POS   = 7; // Parity bit of every status byte
  localparam int WDOG_EN_POS     = 7; // watchdog_enable_bit
  localparam int TW_POS          = 6; // thermal_warning
  localparam int PUMP_FAIL_POS   = 5; // pump_fail_flag
  localparam int WDOG_EVT_POS    = 4; // watchdog_event_flag
  localparam int OPEN_X_POS      = 3; // open_coil_x
  localparam int OPEN_Y_POS      = 2; // open_coil_y
  localparam int OVL_LSB         = 3; // Overload nibble, bits 6..3
  localparam int OVERHEAT_POS    = 2; // overheat_shutdown
  localparam int CUR_MSB         = 4; // peak_amplitude_index top bit
  localparam int STEP_MODE_LSB   = 5; // Step mode field, bits 7..5

  // Widths
  localparam int AMP_W   = 5;  // peak_amplitude_index width
  localparam int POS_W   = 7;  // microstep_position width
  localparam int OVL_W   = 4;  // Overload flags per bridge
  localparam int PIN_W   = 13; // Asynchronous fault pins in total
  localparam int SMODE_W = 3;  // Step mode width

  // Reset values
  localparam logic [7:0]       STATUS_RST = 8'h00;
  localparam logic [AMP_W-1:0] AMP_RST    = 5'h00;
  localparam logic [7:0]       RDATA_RST  = 8'h00;
endpackage
`default_nettype wire

// File: common/ssc_flag_if.sv
`default_nettype none
// Carries raw fault pins to the synchroniser and the clean copies back
interface ssc_flag_if;
  logic [ssc_pkg::PIN_W-1:0] raw;  // Straight from the pins
  logic [ssc_pkg::PIN_W-1:0] safe; // After two flip-flops
  modport sync (input raw, output safe);
  modport user (output raw, input safe);
endinterface
`default_nettype wire

// File: src/ssc_pin_sync.sv
`default_nettype none
// Two-stage synchroniser for the analog fault comparators
module ssc_pin_sync (
  input  wire logic   clk_i,
  input  wire logic   rst_b_i,
  ssc_flag_if.sync    flags
);
  logic [ssc_pkg::PIN_W-1:0] meta_q; // First stage, read by stage two only
  logic [ssc_pkg::PIN_W-1:0] safe_q; // Second stage

  //////////////////////////////////////////////////////////////////////////
  // Both stages clear on reset so no flag reads set before a real fault
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      safe_q <= '0;
    end else begin
      meta_q <= flags.raw;
      safe_q <= meta_q;
    end
  end

  assign flags.safe = safe_q;
endmodule
`default_nettype wire

// File: src/ssc_status_regs.sv
`default_nettype none
// How it works
// - Five-bit code picks rising peak coil current
// - Four read-only status bytes; 04h-06h zero after reset, 07h follows position
// - Byte 04h shows live warning, pump, opens, latched watchdog
// - Byte 05h holds latched X bridge overloads
// - Byte 06h latched Y overloads plus overheat
// - Byte 07h shows live seven-bit step position
// - Watchdog timeout sets flag, hard reset clears it
// - Writing enable bit zero clears watchdog flag
module ssc_status_regs #(
  parameter int AMP_W = ssc_pkg::AMP_W,
  parameter int POS_W = ssc_pkg::POS_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // Register port behind the serial decoder
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic      [7:0]       reg_rdata_o,
  output logic                  reg_rvalid_o,
  // Control towards the current regulator and watchdog
  output logic      [AMP_W-1:0] peak_amplitude_index_o,
  output logic                  watchdog_enable_bit_o,
  // Same-clock sources
  input  wire logic             watchdog_timeout_i,
  input  wire logic [POS_W-1:0] microstep_position_i,
  // Asynchronous fault pins
  input  wire logic             thermal_warning_i,
  input  wire logic             pump_fail_flag_i,
  input  wire logic             open_coil_x_i,
  input  wire logic             open_coil_y_i,
  input  wire logic [3:0]       x_overload_i,
  input  wire logic [3:0]       y_overload_i,
  input  wire logic             overheat_shutdown_i
);
  //////////////////////////////////////////////////////////////////////////
  // Declarations
  ssc_flag_if                           flag_bus ();      // Pin carrier
  logic [ssc_pkg::OVL_W-1:0]            x_ovl_s;          // Synced X faults
  logic [ssc_pkg::OVL_W-1:0]            y_ovl_s;          // Synced Y faults
  logic                                 tw_s;             // Synced warning
  logic                                 pump_s;           // Synced pump fail
  logic                                 open_x_s;         // Synced open X
  logic                                 open_y_s;         // Synced open Y
  logic                                 heat_s;           // Synced overheat
  logic [ssc_pkg::OVL_W-1:0]            x_lat_q;          // Latched X faults
  logic [ssc_pkg::OVL_W-1:0]            y_lat_q;          // Latched Y faults
  logic                                 heat_lat_q;       // Latched overheat
  logic                                 wdog_evt_q;       // Watchdog event
  logic [ssc_pkg::SMODE_W-1:0]          step_mode_q;      // Stored step mode
  logic [AMP_W-1:0]                     amp_q;            // Peak index
  logic                                 watchdog_enable_bit_q;           // Watchdog enable
  logic [7:0]                           rdata_q;          // Read data
  logic                                 rvalid_q;         // Read answer
  logic [7:0]                           sr0;              // Live byte
  logic [7:0]                           sr1;              // X byte
  logic [7:0]                           sr2;              // Y byte
  logic [7:0]                           sr3;              // Position byte
  logic [7:0]                           rd_mux;           // Selected byte
  logic                                 rd_x;             // Read of 05h
  logic                                 rd_y;             // Read of 06h
  logic                                 wd_clr;           // Enable written 0

  // Adds the even-parity bit over the seven data bits
  function automatic logic [7:0] with_check(input logic [6:0] d);
    with_check = {^d, d};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Fault pins pass two flip-flops first
  assign flag_bus.raw = {thermal_warning_i, pump_fail_flag_i, open_coil_x_i,
                         open_coil_y_i, x_overload_i, y_overload_i,
                         overheat_shutdown_i};

  ssc_pin_sync u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .flags   (flag_bus.sync)
  );

  assign {tw_s, pump_s, open_x_s, open_y_s, x_ovl_s, y_ovl_s, heat_s} =
         flag_bus.safe;

  //////////////////////////////////////////////////////////////////////////
  // Access decode
  assign rd_x   = reg_rd_i && (reg_addr_i == ssc_pkg::ADDR_X_OVERLOAD);
  assign rd_y   = reg_rd_i && (reg_addr_i == ssc_pkg::ADDR_Y_OVERLOAD);
  assign wd_clr = reg_wr_i && (reg_addr_i == ssc_pkg::ADDR_WDOG_CTRL) &&
                  !reg_wdata_i[ssc_pkg::WDOG_EN_POS];

  //////////////////////////////////////////////////////////////////////////
  // Control writes; status offsets ignore writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      amp_q       <= ssc_pkg::AMP_RST;
      step_mode_q <= '0;
      watchdog_enable_bit_q      <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ssc_pkg::ADDR_CTRL0) begin
        amp_q       <= reg_wdata_i[AMP_W-1:0];
        step_mode_q <= reg_wdata_i[7:ssc_pkg::STEP_MODE_LSB];
      end else if (reg_addr_i == ssc_pkg::ADDR_WDOG_CTRL) begin
        watchdog_enable_bit_q <= reg_wdata_i[ssc_pkg::WDOG_EN_POS];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Latched faults: a new fault wins over the read that clears
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      x_lat_q    <= '0;
      y_lat_q    <= '0;
      heat_lat_q <= 1'b0;
    end else begin
      x_lat_q    <= (rd_x ? '0 : x_lat_q) | x_ovl_s;
      y_lat_q    <= (rd_y ? '0 : y_lat_q) | y_ovl_s;
      heat_lat_q <= (rd_y ? 1'b0 : heat_lat_q) | heat_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Watchdog event: cleared by the hard reset or by writing enable bit zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdog_evt_q <= 1'b0;
    end else if (watchdog_timeout_i) begin
      wdog_evt_q <= 1'b1;
    end else if (wd_clr) begin
      wdog_evt_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status byte assembly
  always_comb begin
    sr0 = ssc_pkg::STATUS_RST;
    sr0[ssc_pkg::TW_POS]        = tw_s;
    sr0[ssc_pkg::PUMP_FAIL_POS] = pump_s;
    sr0[ssc_pkg::WDOG_EVT_POS]  = wdog_evt_q;
    sr0[ssc_pkg::OPEN_X_POS]    = open_x_s;
    sr0[ssc_pkg::OPEN_Y_POS]    = open_y_s;
    sr1 = ssc_pkg::STATUS_RST;
    sr1[ssc_pkg::OVL_LSB +: ssc_pkg::OVL_W] = x_lat_q;
    sr2 = ssc_pkg::STATUS_RST;
    sr2[ssc_pkg::OVL_LSB +: ssc_pkg::OVL_W] = y_lat_q;
    sr2[ssc_pkg::OVERHEAT_POS] = heat_lat_q;
    sr3 = {1'b0, microstep_position_i};
  end

  //////////////////////////////////////////////////////////////////////////
  // Read select; unmapped offsets answer zero
  always_comb begin
    if (reg_addr_i == ssc_pkg::ADDR_WDOG_CTRL) begin
      rd_mux = {watchdog_enable_bit_q, 7'h00};
    end else if (reg_addr_i == ssc_pkg::ADDR_CTRL0) begin
      rd_mux = {step_mode_q, amp_q};
    end else if (reg_addr_i == ssc_pkg::ADDR_LIVE_FAULT) begin
      rd_mux = with_check(sr0[6:0]);
    end else if (reg_addr_i == ssc_pkg::ADDR_X_OVERLOAD) begin
      rd_mux = with_check(sr1[6:0]);
    end else if (reg_addr_i == ssc_pkg::ADDR_Y_OVERLOAD) begin
      rd_mux = with_check(sr2[6:0]);
    end else if (reg_addr_i == ssc_pkg::ADDR_STEP_POS) begin
      rd_mux = with_check(sr3[6:0]);
    end else begin
      rd_mux = ssc_pkg::RDATA_RST;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read answer one cycle after the strobe, held until the next read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q  <= ssc_pkg::RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata_o            = rdata_q;
  assign reg_rvalid_o           = rvalid_q;
  assign peak_amplitude_index_o = amp_q;
  assign watchdog_enable_bit_o  = watchdog_enable_bit_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_status_read(logic [7:0] a);
    reg_rd_i && (reg_addr_i == a);
  endsequence

  property p_amp_write;
    @(posedge clk_i) disable iff (!rst_b_i)
      (reg_wr_i && reg_addr_i == ssc_pkg::ADDR_CTRL0) |=>
        amp_q == $past(reg_wdata_i[AMP_W-1:0]);
  endproperty
  a_amp_write: assert property (p_amp_write)
    else $error("peak index not taken from write");

  property p_live_read;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_status_read(ssc_pkg::ADDR_LIVE_FAULT) |=>
        rvalid_q && rdata_q[6:0] == $past(sr0[6:0]);
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("live status read wrong");

  property p_check_bit;
    @(posedge clk_i) disable iff (!rst_b_i)
      (reg_rd_i && reg_addr_i[7:2] == ssc_pkg::ADDR_STEP_POS[7:2]) |=>
        rdata_q[ssc_pkg::CHECK_BIT_POS] == ^rdata_q[6:0];
  endproperty
  a_check_bit: assert property (p_check_bit)
    else $error("status parity bit wrong");

  property p_x_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      !rd_x |=> (x_lat_q & $past(x_lat_q)) == $past(x_lat_q);
  endproperty
  a_x_hold: assert property (p_x_hold)
    else $error("latched X fault dropped without read");

  property p_y_set;
    @(posedge clk_i) disable iff (!rst_b_i)
      (y_ovl_s != '0) |=> (y_lat_q & $past(y_ovl_s)) == $past(y_ovl_s);
  endproperty
  a_y_set: assert property (p_y_set)
    else $error("Y fault not latched");

  property p_x_read_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
      (s_status_read(ssc_pkg::ADDR_X_OVERLOAD) ##0 (x_ovl_s == '0)) |=>
        x_lat_q == '0 && rdata_q[6:0] == $past(sr1[6:0]);
  endproperty
  a_x_read_clear: assert property (p_x_read_clear)
    else $error("X faults not cleared by read");

  property p_wd_set;
    @(posedge clk_i) disable iff (!rst_b_i)
      watchdog_timeout_i |=> wdog_evt_q ##1 (wdog_evt_q || $past(wd_clr));
  endproperty
  a_wd_set: assert property (p_wd_set)
    else $error("watchdog flag not set or not held");

  property p_wd_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
      (wd_clr && !watchdog_timeout_i) |=> !wdog_evt_q;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("watchdog flag not cleared");

  property p_wd_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      (wdog_evt_q && !wd_clr) |=> wdog_evt_q;
  endproperty
  a_wd_hold: assert property (p_wd_hold)
    else $error("watchdog flag lost");

  property p_pos_read;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_status_read(ssc_pkg::ADDR_STEP_POS) |=>
        rdata_q[6:0] == $past(microstep_position_i);
  endproperty
  a_pos_read: assert property (p_pos_read)
    else $error("step position read wrong");
endmodule
`default_nettype wire

// File: test/ssc_host_model.sv
`default_nettype none
// Controller model: drives one register byte at a time over the port
module ssc_host_model (
  input  wire logic       clk_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////
  // Idle bus from time zero
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // One write strobe, then the stale bus is scrambled
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    reg_wr_o    = 1'b1;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask

  // One read strobe; data is unknown when no valid came back
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_i);
    reg_rd_o   = 1'b1;
    reg_addr_o = addr;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~addr;
    data       = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
  endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
`default_nettype none
// Self-checking bench for the status and current registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] addr;  // Register written then read
    logic [7:0] wdata; // Byte written
    logic [7:0] rd;    // Byte expected back
    logic [5:0] ctl;   // Expected {enable, amplitude}
  } ssc_row_s;

  logic        clk_i   = 1'b0; // 40 MHz clock
  logic        rst_b_i = 1'b0; // Reset, active low
  logic        wr, rd, rvalid, en, wdt;
  logic [7:0]  addr, wdata, rdata, got;
  logic [4:0]  amp;
  logic [6:0]  pos     = 7'h00; // Translator position
  logic [12:0] pins    = 13'h0000; // All asynchronous fault pins
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  // Rising amplitude only, never a drop across ranges
  ssc_row_s    rows [7] = '{
    '{8'h01, 8'h00, 8'h00, 6'h00}, '{8'h01, 8'he5, 8'he5, 6'h05},
    '{8'h01, 8'h1f, 8'h1f, 6'h1f}, '{8'h00, 8'hff, 8'h80, 6'h3f},
    '{8'h00, 8'h7f, 8'h00, 6'h1f}, '{8'h04, 8'hff, 8'h00, 6'h1f},
    '{8'h0a, 8'hff, 8'h00, 6'h1f}};
  logic [6:0]  posv [3] = '{7'h00, 7'h7f, 7'h55};

  always #12.5 clk_i = ~clk_i;

  initial wdt = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Controller model and the block under test
  ssc_host_model i_host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid));

  ssc_status_regs i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .peak_amplitude_index_o(amp), .watchdog_enable_bit_o(en),
    .watchdog_timeout_i(wdt), .microstep_position_i(pos),
    .thermal_warning_i(pins[12]), .pump_fail_flag_i(pins[11]),
    .open_coil_x_i(pins[10]), .open_coil_y_i(pins[9]),
    .x_overload_i(pins[8:5]), .y_overload_i(pins[4:1]),
    .overheat_shutdown_i(pins[0]));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and run end
  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      mismatches++;
    end
  endtask

  task automatic chk_ctl(input logic [5:0] g, input logic [5:0] e);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      mismatches++;
    end
  endtask

  // Read a byte and compare it
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.read_reg(a, got);
    chk_byte(got, e);
  endtask

  // Set the fault pins, then allow the two synchroniser edges and the latch edge
  task automatic set_pins(input logic [12:0] v);
    @(negedge clk_i);
    pins = v;
    repeat (3) @(negedge clk_i);
  endtask

  // Even parity byte over seven data bits
  function automatic logic [7:0] par(input logic [6:0] v);
    return {^v, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    foreach (rows[i]) begin
      i_host.write_reg(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].rd);
      chk_ctl({en, amp}, rows[i].ctl);
    end
    // Live flags follow the pins both ways
    set_pins(13'h1c00);
    rd_chk(8'h04, par(7'h68));
    set_pins(13'h0000);
    rd_chk(8'h04, 8'h00);
    // X latches hold after the fault, clear on read
    set_pins(13'h0140);
    set_pins(13'h0000);
    rd_chk(8'h05, par(7'h50));
    rd_chk(8'h05, 8'h00);
    // Y latches plus overheat
    set_pins(13'h000b);
    set_pins(13'h0000);
    rd_chk(8'h06, par(7'h2c));
    rd_chk(8'h06, 8'h00);
    // A fault still present at the read stays latched
    set_pins(13'h0100);
    rd_chk(8'h05, par(7'h40));
    set_pins(13'h0000);
    rd_chk(8'h05, par(7'h40));
    rd_chk(8'h05, 8'h00);
    // Position is live and carries parity
    foreach (posv[i]) begin
      @(negedge clk_i);
      pos = posv[i];
      rd_chk(8'h07, par(posv[i]));
    end
    // Watchdog flag holds until enable is written low
    @(negedge clk_i);
    wdt = 1'b1;
    @(negedge clk_i);
    wdt = 1'b0;
    rd_chk(8'h04, par(7'h10));
    i_host.write_reg(8'h00, 8'h80);
    rd_chk(8'h04, par(7'h10));
    i_host.write_reg(8'h00, 8'h00);
    rd_chk(8'h04, 8'h00);
    // Mid-run hard reset with flags set clears everything
    i_host.write_reg(8'h00, 8'h80);
    rd_chk(8'h00, 8'h80);
    set_pins(13'h01e0);
    set_pins(13'h0000);
    @(negedge clk_i);
    wdt = 1'b1;
    pos = 7'h00;
    @(negedge clk_i);
    wdt     = 1'b0;
    rst_b_i = 1'b0;
    #1;
    chk_ctl({en, amp}, 6'h00);
    chk_byte(rdata, 8'h00);
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (int a = 4; a < 8; a++) begin
      rd_chk(8'(a), 8'h00);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
